/* File: rtl/lcdqm_duty_timer.sv */
module lcdqm_duty_timer #(
  parameter int unsigned PRESCALE = lcdqm_pkg::LCD_PRESCALE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] div_sel_i,
  output logic            duty_tick_o
);
  import lcdqm_pkg::*;

  logic [15:0]           pre_reg;
  logic [DUTY_DIV_W-1:0] div_reg;
  logic [DUTY_DIV_W-1:0] div_last;
  logic                  lcd_tick;

  assign lcd_tick    = run_i && (pre_reg == 16'(PRESCALE - 1));
  assign div_last    = DUTY_DIV_W'((1 << (DUTY_DIV_LOG2_MIN + 32'(div_sel_i))) - 1);
  assign duty_tick_o = lcd_tick && (div_reg >= div_last);

  // Source clock for the panel
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || lcd_tick) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  // Duty cycle is 2^(6+sel) source clocks; lowering sel mid-count ends early
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      div_reg <= '0;
    end else if (lcd_tick) begin
      div_reg <= (div_reg >= div_last) ? '0 : div_reg + 1'b1;
    end
  end

  // Gap checker helper
  logic [19:0] gap_reg;
  logic        gap_ok_reg;
  logic [1:0]  sel_d_reg;
  always_ff @(posedge clk_i) begin
    sel_d_reg <= div_sel_i;
    if (rst_i || !run_i || sel_d_reg != div_sel_i) begin
      gap_reg    <= 20'h0_0000;
      gap_ok_reg <= 1'b0;
    end else if (duty_tick_o) begin
      gap_reg    <= 20'h0_0000;
      gap_ok_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 20'h0_0001;
    end
  end

  chk_duty_length: assert property (@(posedge clk_i) disable iff (rst_i)
    (duty_tick_o && gap_ok_reg && sel_d_reg == div_sel_i) |->
      (32'(gap_reg) + 1 == PRESCALE * (32'd1 << (DUTY_DIV_LOG2_MIN + 32'(div_sel_i)))))
    else $error("duty cycle length wrong");

endmodule

/* File: rtl/lcdqm_pkg.sv */
package lcdqm_pkg;

  // Panel geometry
  localparam int unsigned SEG_COUNT = 40;
  localparam int unsigned COM_COUNT = 4;
  localparam int unsigned COM_IDX_W = 2;

  // Printed register offsets; the word index is the offset less the base
  localparam logic [31:0] REG_BASE     = 32'hffff_fb00;
  localparam logic [31:0] CLKSEL_OFFS  = 32'hffff_fb00;
  localparam logic [31:0] MODE_OFFS    = 32'hffff_fb01;
  localparam logic [31:0] SEG_OFFS     = 32'hffff_fb20;
  localparam logic [7:0]  CLKSEL_IDX   = 8'(CLKSEL_OFFS - REG_BASE);
  localparam logic [7:0]  MODE_IDX     = 8'(MODE_OFFS - REG_BASE);
  localparam logic [7:0]  SEG_IDX      = 8'(SEG_OFFS - REG_BASE);
  localparam logic [7:0]  SEG_IDX_LAST = 8'(SEG_IDX + 8'(SEG_COUNT - 1));

  // Field positions
  localparam int unsigned DISP_EN_POS  = 7;
  localparam int unsigned PWR_POS      = 4;
  localparam int unsigned SEG_DATA_MSB = 3;
  localparam int unsigned DUTY_SEL_MSB = 1;
  localparam int unsigned CLKSEL_MSB   = 4;
  localparam int unsigned BITWR_VAL    = 11;
  localparam int unsigned BITWR_IDX_LO = 8;

  // Values after reset
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] CLKSEL_RST = 8'h00;
  localparam logic [3:0] SEG_RST    = 4'h0;

  // Timing: bus clock and the LCD source clock made from it
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned LCD_CLK_HZ        = 125_000;
  localparam int unsigned LCD_PRESCALE_CYC  = CLK_HZ / LCD_CLK_HZ;
  localparam int unsigned DUTY_DIV_LOG2_MIN = 6;
  localparam int unsigned DUTY_DIV_W        = 9;

  typedef struct packed {
    logic                 polarity;
    logic                 powered;
    logic [COM_COUNT-1:0] com;
    logic [SEG_COUNT-1:0] seg;
  } lcdqm_drive_s;

endpackage

/* File: rtl/lcdqm_scan_driver.sv */
module lcdqm_scan_driver #(
  parameter int unsigned ADR_W    = 10,
  parameter int unsigned PRESCALE = lcdqm_pkg::LCD_PRESCALE_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [ADR_W-1:0]        adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output lcdqm_pkg::lcdqm_drive_s      drive_o
);
  import lcdqm_pkg::*;

  logic [7:0]             mode_reg;
  logic [7:0]             clksel_reg;
  logic [3:0]             seg_reg [SEG_COUNT];
  logic                   ack_reg;
  logic [31:0]            dat_reg;
  logic [COM_IDX_W-1:0]   com_idx_reg;
  logic                   pol_reg;
  lcdqm_drive_s           drive_reg;
  lcdqm_drive_s           drive_next;
  logic                   duty_tick;
  logic                   powered;
  logic                   disp_en;
  logic                   req;
  logic                   wr_fire;
  logic [7:0]             idx;
  logic [7:0]             rd_byte;
  logic [7:0]             clksel_merged;

  // Word index from the byte address
  assign idx     = 8'(adr_i[ADR_W-1:2]);
  assign req     = cyc_i && stb_i;
  assign wr_fire = req && we_i && ack_reg;
  assign powered = mode_reg[PWR_POS];
  assign disp_en = mode_reg[DISP_EN_POS];

  function automatic logic is_seg(input logic [7:0] i);
    return (i >= SEG_IDX) && (i <= SEG_IDX_LAST);
  endfunction

  // Byte lane 0 writes the byte; lane 1 writes one bit (index, value)
  function automatic logic [7:0] merge_byte(input logic [7:0]  old,
                                            input logic [3:0]  sel,
                                            input logic [31:0] dat);
    logic [7:0] val;
    val = old;
    if (sel[0]) begin
      val = dat[7:0];
    end
    if (sel[1]) begin
      val[dat[BITWR_IDX_LO+:3]] = dat[BITWR_VAL];
    end
    return val;
  endfunction

  // Bus answer: one wait state, ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (idx == MODE_IDX) begin
      rd_byte = mode_reg;
    end else if (idx == CLKSEL_IDX) begin
      rd_byte = clksel_reg;
    end else if (is_seg(idx)) begin
      rd_byte = {4'h0, seg_reg[6'(idx - SEG_IDX)]};
    end
  end

  // Read data latched on the taking edge, stable while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg && !we_i) begin
      dat_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // Mode register; unused bits kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RST;
    end else if (wr_fire && idx == MODE_IDX) begin
      mode_reg <= merge_byte(mode_reg, sel_i, dat_i);
    end
  end

  // Clock select; bits above the source field read zero
  assign clksel_merged = merge_byte(clksel_reg, sel_i, dat_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clksel_reg <= CLKSEL_RST;
    end else if (wr_fire && idx == CLKSEL_IDX) begin
      clksel_reg <= {3'b000, clksel_merged[CLKSEL_MSB:0]};
    end
  end

  // Forty segment registers; high nibble dropped on write
  for (genvar k = 0; k < SEG_COUNT; k++) begin : g_seg
    logic [7:0] seg_merged;
    assign seg_merged = merge_byte({4'h0, seg_reg[k]}, sel_i, dat_i);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        seg_reg[k] <= SEG_RST;
      end else if (wr_fire && idx == 8'(SEG_IDX + 8'(k))) begin
        seg_reg[k] <= seg_merged[SEG_DATA_MSB:0];
      end
    end
  end

  lcdqm_duty_timer #(
    .PRESCALE (PRESCALE)
  ) u_timer (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (powered),
    .div_sel_i   (clksel_reg[DUTY_SEL_MSB:0]),
    .duty_tick_o (duty_tick)
  );

  // Common scan, ascending with wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || !powered) begin
      com_idx_reg <= '0;
    end else if (duty_tick) begin
      com_idx_reg <= com_idx_reg + 1'b1;
    end
  end

  // Frame polarity flips when the scan wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || !powered) begin
      pol_reg <= 1'b0;
    end else if (duty_tick && com_idx_reg == COM_IDX_W'(COM_COUNT - 1)) begin
      pol_reg <= !pol_reg;
    end
  end

  // Level per line: 1 selection, 0 non-selection; polarity set by drive_o.polarity
  always_comb begin
    drive_next          = '0;
    drive_next.powered  = powered;
    drive_next.polarity = pol_reg;
    if (powered) begin
      drive_next.com[com_idx_reg] = 1'b1;
      for (int k = 0; k < SEG_COUNT; k++) begin
        // Data ignored while blank, keeps the glass off
        drive_next.seg[k] = disp_en && seg_reg[k][com_idx_reg];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive_o = drive_reg;

  sequence s_req_taken;
    req && !ack_reg;
  endsequence

  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  chk_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_taken |=> s_ack_pulse)
    else $error("bus ack not a single pulse");

  chk_blank_display: assert property (@(posedge clk_i) disable iff (rst_i)
    !disp_en |=> drive_o.seg == '0)
    else $error("segment driven while display disabled");

  chk_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !powered |=> (drive_o.com == '0) && !drive_o.powered && (com_idx_reg == '0))
    else $error("drive active while unpowered");

  chk_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> (mode_reg == MODE_RST) && (seg_reg[0] == SEG_RST)
              && (seg_reg[SEG_COUNT-1] == SEG_RST))
    else $error("registers not cleared by reset");

  chk_one_common: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_o.powered |-> $onehot(drive_o.com))
    else $error("common lines overlap");

  chk_seg_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (powered && disp_en) |=>
      drive_o.seg[0] == $past(seg_reg[0][com_idx_reg])
      && drive_o.seg[SEG_COUNT-1] == $past(seg_reg[SEG_COUNT-1][com_idx_reg]))
    else $error("segment level not from selected bit");

  chk_seg_own_com: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_o.seg[0] |-> drive_o.com[0] == $past(seg_reg[0][0] && com_idx_reg == '0)
                       || !drive_o.com[0])
    else $error("segment active outside its common");

  chk_scan_order: assert property (@(posedge clk_i) disable iff (rst_i)
    (duty_tick && powered) |=> com_idx_reg == $past(com_idx_reg) + 1'b1)
    else $error("common scan not ascending");

  chk_pol_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    (duty_tick && powered && com_idx_reg == COM_IDX_W'(COM_COUNT - 1)) |=>
      pol_reg != $past(pol_reg) ##1 drive_o.polarity == pol_reg)
    else $error("polarity not inverted at frame end");

  chk_seg_read_hi: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_taken ##0 (!we_i && is_seg(idx))) |=> dat_o[7:4] == 4'h0)
    else $error("segment register upper bits not zero");

  sequence s_write_hit;
    req && we_i && ack_reg;
  endsequence

  chk_mode_byte_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_write_hit ##0 (idx == MODE_IDX && sel_i == 4'h1)) |=>
      mode_reg == $past(dat_i[7:0]))
    else $error("mode byte write lost");

  chk_mode_bit_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_write_hit ##0 (idx == MODE_IDX && sel_i == 4'h2)) |=>
      mode_reg[$past(dat_i[BITWR_IDX_LO+:3])] == $past(dat_i[BITWR_VAL]))
    else $error("mode bit write lost");

  chk_seg_byte_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_write_hit ##0 (is_seg(idx) && sel_i == 4'h1)) |=>
      seg_reg[6'($past(idx) - SEG_IDX)] == $past(dat_i[SEG_DATA_MSB:0]))
    else $error("segment byte write lost");

  chk_mode_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_taken ##0 (!we_i && idx == MODE_IDX)) |=>
      dat_o == {24'h00_0000, $past(mode_reg)})
    else $error("mode read data wrong");

  chk_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_req_taken ##0 !we_i) |=> dat_o[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");

  chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_o)
    else $error("ack without request");

  chk_com_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (powered && !duty_tick) |=> $stable(com_idx_reg))
    else $error("common changed inside a duty cycle");

  chk_scan_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (duty_tick && powered && com_idx_reg == COM_IDX_W'(COM_COUNT - 1)) |=>
      com_idx_reg == '0)
    else $error("scan did not wrap after four duty cycles");

  chk_pol_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (powered && !(duty_tick && com_idx_reg == COM_IDX_W'(COM_COUNT - 1))) |=>
      $stable(pol_reg))
    else $error("polarity changed inside a frame");

  // Every segment line against its own register bit
  for (genvar k = 0; k < SEG_COUNT; k++) begin : g_chk_seg
    chk_seg_on: assert property (@(posedge clk_i) disable iff (rst_i)
      (powered && disp_en && seg_reg[k][com_idx_reg]) |=> drive_o.seg[k])
      else $error("segment not at selection level");

    chk_seg_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (powered && !seg_reg[k][com_idx_reg]) |=> !drive_o.seg[k])
      else $error("segment not at non-selection level");
  end

endmodule

/* File: verif/lcdqm_panel_model.sv */
// Passive glass: shows what a selected common lights
module lcdqm_panel_model (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire lcdqm_pkg::lcdqm_drive_s     drive_i,
  output logic [lcdqm_pkg::SEG_COUNT-1:0]  lit_o,
  output logic [1:0]                       idx_o,
  output logic                             fault_o
);
  import lcdqm_pkg::*;
  always_comb begin
    idx_o = 2'd0;
    for (int i = 0; i < COM_COUNT; i++) begin
      if (drive_i.com[i]) begin
        idx_o = 2'(i);
      end
    end
    lit_o = (drive_i.com != 4'h0) ? drive_i.seg : '0;
  end

  // Overlapping commons or segments with no common would show ghosts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if ($countones(drive_i.com) > 1) begin
      fault_o <= 1'b1;
    end else if (drive_i.com == 4'h0 && drive_i.seg != '0) begin
      fault_o <= 1'b1;
    end
  end
endmodule

/* File: verif/test_lcdqm_scan_driver.sv */
module test_lcdqm_scan_driver;
  timeunit 1ns;
  timeprecision 1ns;
  import lcdqm_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, rng = 32'd12734;
  logic ack_o, fault;
  lcdqm_drive_s drive_o;
  logic [39:0] lit;
  logic [1:0] idx;
  logic [3:0] segm [SEG_COUNT];
  logic [31:0] rdq [$];
  int miscompares = 0, compares = 0;

  always #25 clk_i = ~clk_i;

  lcdqm_scan_driver #(.ADR_W(10), .PRESCALE(2)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .drive_o(drive_o));
  lcdqm_panel_model pan (.clk_i(clk_i), .rst_i(rst_i), .drive_i(drive_o), .lit_o(lit),
    .idx_o(idx), .fault_o(fault));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic cycle; reads note their expected byte first
  task automatic wb(input logic [9:0] a, input logic [3:0] s, input logic [31:0] d,
                    input logic w, input logic [31:0] exp);
    if (!w) rdq.push_back(exp);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk(64'(dat_o), 64'(rdq.pop_front()));
    end
  end

  // Follow five duty cycles: length, order, data, polarity
  task automatic scan(input int len, input logic en);
    int n;
    logic [3:0] c;
    logic [1:0] ci;
    logic p;
    logic [39:0] e;
    c = drive_o.com;
    n = 0;
    while (drive_o.com === c && n < 3000) begin @(negedge clk_i); n++; end
    for (int d = 0; d < 5; d++) begin
      c = drive_o.com; ci = idx; p = drive_o.polarity;
      for (int k = 0; k < SEG_COUNT; k++) e[k] = en & segm[k][ci];
      chk(64'(lit), 64'(e));
      n = 0;
      do begin @(negedge clk_i); n++; end while (drive_o.com === c && n < 3000);
      chk(64'(n), 64'(len));
      chk(64'(drive_o.com), 64'(4'b0001 << 2'(ci + 2'd1)));
      chk(64'(drive_o.polarity), 64'(p ^ (ci == 2'd3)));
      chk(64'(drive_o.powered), 64'(1));
    end
    // Bus requests start just after a rising edge
    @(posedge clk_i);
  endtask

  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(10'h004, 4'h1, 0, 0, 0);
    wb(10'h000, 4'h1, 0, 0, 0);
    wb(10'h080, 4'h1, 0, 0, 0);
    wb(10'h11c, 4'h1, 0, 0, 0);
    for (int k = 0; k < SEG_COUNT; k++) begin
      d = xs();
      segm[k] = d[3:0];
      wb(10'(10'h080 + 4 * k), 4'h1, d, 1, 0);
    end
    segm[5][2] = 1'b1;
    wb(10'h094, 4'h2, 32'h0000_0a00, 1, 0);
    for (int k = 0; k < SEG_COUNT; k++) begin
      wb(10'(10'h080 + 4 * k), 4'h1, xs(), 0, {28'h000_0000, segm[k]});
    end
    wb(10'h3fc, 4'h1, xs(), 0, 0);
    wb(10'h004, 4'h2, 32'h0000_0c00, 1, 0);
    wb(10'h004, 4'h1, 0, 0, 32'h0000_0010);
    wb(10'h004, 4'h2, 32'h0000_0f00, 1, 0);
    wb(10'h004, 4'h1, 0, 0, 32'h0000_0090);
    scan(128, 1'b1);
    wb(10'h000, 4'h1, 32'h0000_0001, 1, 0);
    scan(256, 1'b1);
    wb(10'h000, 4'h1, 32'h0000_0002, 1, 0);
    scan(512, 1'b1);
    wb(10'h004, 4'h1, 32'h0000_0010, 1, 0);
    wb(10'h000, 4'h1, 32'h0000_0003, 1, 0);
    scan(1024, 1'b0);
    wb(10'h004, 4'h1, 32'h0000_0000, 1, 0);
    repeat (4) @(negedge clk_i);
    chk(64'(drive_o), 64'(0));
    chk(64'(fault), 64'(0));
    // Reset in mid-run must clear what was written
    @(posedge clk_i);
    wb(10'h004, 4'h1, 32'h0000_0090, 1, 0);
    wb(10'h080, 4'h1, 32'h0000_000f, 1, 0);
    wb(10'h11c, 4'h1, 32'h0000_0005, 1, 0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(10'h004, 4'h1, 0, 0, 0);
    wb(10'h080, 4'h1, 0, 0, 0);
    wb(10'h11c, 4'h1, 0, 0, 0);
    wb(10'h000, 4'h1, 0, 0, 0);
    chk(64'(drive_o), 64'(0));
    close_out();
  end

  // Whole run needs under 15000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule
